// File: shared/sdp_map.vh
`ifndef SDP_MAP_VH
`define SDP_MAP_VH
`define SDP_CMD_RDMEM 8'h0d
`define SDP_CMD_CRC 8'h0e
`define SDP_CMD_STEP 8'h10
`define SDP_CMD_STUFF 8'h11
`define SDP_CMD_EXEC 8'h12
`define SDP_SYNC_CHAR 8'h80
`define SDP_AUTOBAUD_BITS 8
`define SDP_MAX_DIV 512
`define SDP_MIN_DIV 4
`define SDP_DATA_BITS 8
`define SDP_CRC_INIT 16'hffff
`define SDP_CRC_POLY 16'h1021
`define SDP_NOT_HALTED_BYTE 8'hff
`define SDP_NOT_HALTED_CRC 16'hffff
`define SDP_PMEM_SIZE 17'h10000
`endif

// File: design/sdp_serial_debug_port.v
`include "sdp_map.vh"
`default_nettype none
module sdp_serial_debug_port #(
   parameter PMEM_AW = 16
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // debug line pin
   input wire debug_serial_line_i,
   output reg debug_serial_line_o,
   output reg debug_serial_line_oe_o,
   // processor status
   input wire cpu_halted_i,
   input wire read_protect_i,
   input wire stop_mode_i,
   // data memory read port
   output reg dmem_rd_o,
   output reg [15:0] dmem_addr_o,
   input wire [7:0] dmem_data_i,
   // program memory read port
   output reg pmem_rd_o,
   output reg [PMEM_AW-1:0] pmem_addr_o,
   input wire [7:0] pmem_data_i,
   // instruction injection to the cpu
   output reg instr_valid_o,
   output reg [2:0] instr_kind_o,
   output reg [7:0] instr_byte_o,
   output reg instr_last_o,
   input wire [2:0] instr_len_i,
   // reset request
   output reg sys_reset_req_o
);
   // =====================================================
   // receiver with autobaud
   // =====================================================
   localparam DW = 10;
   localparam [2:0] RX_WAIT = 3'h0, RX_MEAS = 3'h1, RX_IDLE = 3'h2,
      RX_BITS = 3'h3, RX_STOP = 3'h4;
   reg [2:0] rx_st_ff;
   reg [12:0] meas_ff;
   reg [DW-1:0] div_ff;
   reg locked_ff;
   reg [DW-1:0] rcnt_ff;
   reg [3:0] rbit_ff;
   reg [7:0] rsh_ff;
   reg rx_stb_ff;
   reg [7:0] rx_byte_ff;
   reg line_q_ff;
   reg tx_busy;
   wire line_in = tx_busy ? 1'b1 : debug_serial_line_i;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_st_ff <= RX_WAIT;
         meas_ff <= 13'h0;
         div_ff <= 10'h0;
         locked_ff <= 1'b0;
         rcnt_ff <= 10'h0;
         rbit_ff <= 4'h0;
         rsh_ff <= 8'h0;
         rx_stb_ff <= 1'b0;
         rx_byte_ff <= 8'h0;
         line_q_ff <= 1'b1;
      end else begin
         line_q_ff <= line_in;
         rx_stb_ff <= 1'b0;
         case (rx_st_ff)
            RX_WAIT: begin
               meas_ff <= 13'h1;
               if (!line_in)
                  rx_st_ff <= RX_MEAS;
            end
            RX_MEAS: begin
               if (line_in) begin
                  // eight low bits measured: bit period = count / 8
                  div_ff <= meas_ff[12:3];
                  locked_ff <= 1'b1;
                  rx_st_ff <= RX_IDLE;
               end else if (meas_ff != 13'h1fff) begin
                  meas_ff <= meas_ff + 13'h1;
               end
            end
            RX_IDLE: begin
               if (line_q_ff && !line_in) begin
                  rcnt_ff <= {1'b0, div_ff[DW-1:1]};
                  rbit_ff <= 4'h0;
                  rx_st_ff <= RX_BITS;
               end
            end
            RX_BITS: begin
               if (rcnt_ff == 10'h0) begin
                  rcnt_ff <= div_ff - 10'h1;
                  if (rbit_ff == 4'h0 && line_in) begin
                     rx_st_ff <= RX_IDLE;
                  end else if (rbit_ff == 4'h9) begin
                     rx_st_ff <= RX_IDLE;
                     if (line_in) begin
                        rx_stb_ff <= 1'b1;
                        rx_byte_ff <= rsh_ff;
                     end
                  end else begin
                     if (rbit_ff != 4'h0)
                        rsh_ff <= {line_in, rsh_ff[7:1]};
                     rbit_ff <= rbit_ff + 4'h1;
                  end
               end else begin
                  rcnt_ff <= rcnt_ff - 10'h1;
               end
            end
            default: rx_st_ff <= RX_WAIT;
         endcase
      end
   end
   // =====================================================
   // two-entry reply buffer
   // =====================================================
   reg [7:0] buf_ff [0:1];
   reg [1:0] bcnt_ff;
   reg bwr_ff, brd_ff;
   reg push;
   reg [7:0] push_data;
   wire buf_ready = (bcnt_ff != 2'h2);
   wire buf_valid = (bcnt_ff != 2'h0);
   wire pop;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         buf_ff[0] <= 8'h0;
         buf_ff[1] <= 8'h0;
         bcnt_ff <= 2'h0;
         bwr_ff <= 1'b0;
         brd_ff <= 1'b0;
      end else begin
         if (push && buf_ready) begin
            buf_ff[bwr_ff] <= push_data;
            bwr_ff <= ~bwr_ff;
         end
         if (pop)
            brd_ff <= ~brd_ff;
         bcnt_ff <= bcnt_ff + {1'b0, push && buf_ready} - {1'b0, pop};
      end
   end
   // =====================================================
   // transmitter
   // =====================================================
   reg [DW-1:0] tcnt_ff;
   reg [3:0] tbit_ff;
   reg [9:0] tsh_ff;
   reg tact_ff;
   assign pop = buf_valid && !tact_ff;
   always @* tx_busy = tact_ff || buf_valid;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tcnt_ff <= 10'h0;
         tbit_ff <= 4'h0;
         tsh_ff <= 10'h3ff;
         tact_ff <= 1'b0;
         debug_serial_line_o <= 1'b1;
         debug_serial_line_oe_o <= 1'b0;
      end else begin
         debug_serial_line_oe_o <= tx_busy;
         debug_serial_line_o <= tact_ff ? tsh_ff[0] : 1'b1;
         if (pop) begin
            tsh_ff <= {1'b1, buf_ff[brd_ff], 1'b0};
            tact_ff <= 1'b1;
            tbit_ff <= 4'h0;
            tcnt_ff <= div_ff - 10'h1;
         end else if (tact_ff) begin
            if (tcnt_ff == 10'h0) begin
               tcnt_ff <= div_ff - 10'h1;
               tsh_ff <= {1'b1, tsh_ff[9:1]};
               if (tbit_ff == 4'h9)
                  tact_ff <= 1'b0;
               tbit_ff <= tbit_ff + 4'h1;
            end else begin
               tcnt_ff <= tcnt_ff - 10'h1;
            end
         end
      end
   end
   // =====================================================
   // command controller
   // =====================================================
   localparam [2:0] C_CMD = 3'h0, C_ARG = 3'h1, C_RDM = 3'h2,
      C_CRC = 3'h3, C_CRC2 = 3'h4, C_INJ = 3'h5;
   reg [2:0] c_st_ff;
   reg [7:0] cmd_ff;
   reg [2:0] argn_ff;
   reg [16:0] left_ff;
   reg [15:0] crc_ff;
   reg [16:0] pcnt_ff;
   reg rdm_wait_ff, crc_hi_ff, ok_ff;
   function [15:0] crc_step;
      input [15:0] c;
      input [7:0] d;
      integer i;
      reg [15:0] r;
      begin
         r = c ^ {d, 8'h00};
         for (i = 0; i < 8; i = i + 1)
            r = r[15] ? ({r[14:0], 1'b0} ^ `SDP_CRC_POLY) : {r[14:0], 1'b0};
         crc_step = r;
      end
   endfunction
   wire allowed = cpu_halted_i && !read_protect_i;
   always @* begin
      push = 1'b0;
      push_data = 8'h0;
      if (c_st_ff == C_RDM && rdm_wait_ff) begin
         push = 1'b1;
         push_data = cpu_halted_i ? dmem_data_i :
            `SDP_NOT_HALTED_BYTE;
      end else if (c_st_ff == C_CRC2) begin
         push = 1'b1;
         push_data = crc_hi_ff ? crc_ff[15:8] : crc_ff[7:0];
      end
   end
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         c_st_ff <= C_CMD;
         cmd_ff <= 8'h0;
         argn_ff <= 3'h0;
         left_ff <= 17'h0;
         crc_ff <= `SDP_CRC_INIT;
         pcnt_ff <= 17'h0;
         rdm_wait_ff <= 1'b0;
         crc_hi_ff <= 1'b0;
         ok_ff <= 1'b0;
         dmem_rd_o <= 1'b0;
         dmem_addr_o <= 16'h0;
         pmem_rd_o <= 1'b0;
         pmem_addr_o <= {PMEM_AW{1'b0}};
         instr_valid_o <= 1'b0;
         instr_kind_o <= 3'h0;
         instr_byte_o <= 8'h0;
         instr_last_o <= 1'b0;
         sys_reset_req_o <= 1'b0;
      end else begin
         sys_reset_req_o <= stop_mode_i && !debug_serial_line_i;
         dmem_rd_o <= 1'b0;
         pmem_rd_o <= 1'b0;
         instr_valid_o <= 1'b0;
         instr_last_o <= 1'b0;
         case (c_st_ff)
            C_CMD: if (rx_stb_ff && locked_ff) begin
               cmd_ff <= rx_byte_ff;
               argn_ff <= 3'h0;
               ok_ff <= allowed;
               case (rx_byte_ff)
                  `SDP_CMD_RDMEM: c_st_ff <= C_ARG;
                  `SDP_CMD_CRC: begin
                     crc_ff <= `SDP_CRC_INIT;
                     pcnt_ff <= 17'h0;
                     pmem_addr_o <= {PMEM_AW{1'b0}};
                     pmem_rd_o <= cpu_halted_i;
                     crc_hi_ff <= 1'b1;
                     if (cpu_halted_i)
                        c_st_ff <= C_CRC;
                     else begin
                        crc_ff <= `SDP_NOT_HALTED_CRC;
                        c_st_ff <= C_CRC2;
                     end
                  end
                  `SDP_CMD_STEP: begin
                     instr_valid_o <= allowed;
                     instr_kind_o <= 3'h0;
                     instr_last_o <= 1'b1;
                  end
                  `SDP_CMD_STUFF: c_st_ff <= C_INJ;
                  `SDP_CMD_EXEC: c_st_ff <= C_INJ;
                  default: c_st_ff <= C_CMD;
               endcase
            end
            C_ARG: if (rx_stb_ff) begin
               argn_ff <= argn_ff + 3'h1;
               case (argn_ff)
                  3'h0: dmem_addr_o[15:8] <= rx_byte_ff;
                  3'h1: dmem_addr_o[7:0] <= rx_byte_ff;
                  3'h2: left_ff[15:8] <= rx_byte_ff;
                  default: begin
                     // zero size means the full 64k
                     left_ff <= ({left_ff[15:8], rx_byte_ff} == 16'h0) ?
                        17'h10000 : {1'b0, left_ff[15:8], rx_byte_ff};
                     c_st_ff <= C_RDM;
                     rdm_wait_ff <= 1'b0;
                  end
               endcase
            end
            C_RDM: begin
               if (rdm_wait_ff) begin
                  if (buf_ready) begin
                     rdm_wait_ff <= 1'b0;
                     dmem_addr_o <= dmem_addr_o + 16'h1;
                     left_ff <= left_ff - 17'h1;
                     if (left_ff == 17'h1)
                        c_st_ff <= C_CMD;
                  end
               end else begin
                  dmem_rd_o <= cpu_halted_i;
                  rdm_wait_ff <= 1'b1;
               end
            end
            C_CRC: begin
               // one byte per clock over program memory
               crc_ff <= crc_step(crc_ff, pmem_data_i);
               pcnt_ff <= pcnt_ff + 17'h1;
               pmem_addr_o <= pmem_addr_o + {{(PMEM_AW-1){1'b0}}, 1'b1};
               pmem_rd_o <= 1'b1;
               if (pcnt_ff == (17'h1 << PMEM_AW) - 17'h1) begin
                  pmem_rd_o <= 1'b0;
                  c_st_ff <= C_CRC2;
               end
            end
            C_CRC2: if (buf_ready) begin
               crc_hi_ff <= 1'b0;
               if (!crc_hi_ff)
                  c_st_ff <= C_CMD;
            end
            C_INJ: if (rx_stb_ff) begin
               instr_valid_o <= ok_ff;
               instr_kind_o <= (cmd_ff == `SDP_CMD_STUFF) ? 3'h1 : 3'h2;
               instr_byte_o <= rx_byte_ff;
               argn_ff <= argn_ff + 3'h1;
               if (cmd_ff == `SDP_CMD_STUFF ||
                   argn_ff + 3'h1 >= instr_len_i) begin
                  instr_last_o <= 1'b1;
                  c_st_ff <= C_CMD;
               end
            end
            default: c_st_ff <= C_CMD;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: verif/sdp_host.sv
`default_nettype none
module sdp_host #(
   parameter int BIT = 16
) (
   input wire logic clk_i,
   input wire logic line_i,
   output var logic drv_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // host side of the debug line
   initial drv_o = 1'b1;
   task automatic level(input logic v);
      @(posedge clk_i);
      #1 drv_o = v;
   endtask
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      repeat (BIT * (1 + $urandom_range(2))) @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i);
         #1 drv_o = f[i];
         repeat (BIT - 1) @(posedge clk_i);
      end
   endtask
   task automatic recv(output logic [7:0] b);
      int n;
      b = 8'hxx;
      n = 0;
      while (line_i !== 1'b0 && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
      if (n < 4000) begin
         repeat (BIT / 2) @(posedge clk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_i);
            b[i] = line_i;
         end
         repeat (BIT) @(posedge clk_i);
         if (line_i !== 1'b1) b = 8'hxx;
      end
   endtask
endmodule
`default_nettype wire

// File: verif/sdp_serial_debug_port_asserts.sv
`default_nettype none
module sdp_serial_debug_port_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic debug_serial_line_i,
   input wire logic debug_serial_line_o,
   input wire logic debug_serial_line_oe_o,
   input wire logic cpu_halted_i,
   input wire logic read_protect_i,
   input wire logic stop_mode_i,
   input wire logic dmem_rd_o,
   input wire logic instr_valid_o,
   input wire logic [2:0] instr_kind_o,
   input wire logic instr_last_o,
   input wire logic sys_reset_req_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic heard_ff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         heard_ff <= 1'b0;
      end else if (!debug_serial_line_i) begin
         heard_ff <= 1'b1;
      end
   end
   sequence drop_s;
      $fell(debug_serial_line_o) && debug_serial_line_oe_o;
   endsequence
   sequence drive_on_s;
      $rose(debug_serial_line_oe_o);
   endsequence
   low_hold_a: assert property (
      drop_s |=> !debug_serial_line_o [*3])
      else $error("low bit too short");
   stop_high_a: assert property (
      $fell(debug_serial_line_oe_o) |-> $past(debug_serial_line_o))
      else $error("release without stop bit");
   oe_hold_a: assert property (
      drive_on_s |-> debug_serial_line_oe_o [*8])
      else $error("drive dropped early");
   rd_gate_a: assert property (
      dmem_rd_o |-> cpu_halted_i)
      else $error("memory read while running");
   req_set_a: assert property (
      stop_mode_i && !debug_serial_line_i |=> sys_reset_req_o)
      else $error("no reset request");
   req_clear_a: assert property (!stop_mode_i |=> !sys_reset_req_o)
      else $error("spurious reset request");
   instr_gate_a: assert property (
      instr_valid_o |-> cpu_halted_i && !read_protect_i)
      else $error("injection while refused");
   one_byte_a: assert property (
      instr_valid_o && instr_kind_o != 3'h2 |-> instr_last_o)
      else $error("step or stuff not single");
   quiet_idle_a: assert property (
      !heard_ff |-> !debug_serial_line_oe_o && !instr_valid_o && !dmem_rd_o)
      else $error("active before line data");
endmodule
`default_nettype wire

// File: verif/sdp_serial_debug_port_bench.sv
`include "sdp_map.vh"
`default_nettype none
module sdp_serial_debug_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT = 16;
   logic clk_i = 0, rst_i = 1, halt = 1, prot = 0, stop = 0;
   logic drv, lo, oe, drd, prd, iv, il, req;
   logic [7:0] dmd = 8'h00, pmd = 8'h00, ib;
   logic [2:0] len = 3'h1, ik;
   logic [15:0] da;
   logic [3:0] pa;
   logic [11:0] q[$];
   int bad_count = 0, samples_checked = 0, n, prd_n = 0;
   wire logic line_w = oe ? lo : drv;
   always #5 clk_i = ~clk_i;
   sdp_serial_debug_port #(.PMEM_AW(4)) sdp_serial_debug_port_inst (
      .clk_i(clk_i), .rst_i(rst_i), .debug_serial_line_i(line_w),
      .debug_serial_line_o(lo), .debug_serial_line_oe_o(oe),
      .cpu_halted_i(halt), .read_protect_i(prot), .stop_mode_i(stop),
      .dmem_rd_o(drd), .dmem_addr_o(da), .dmem_data_i(dmd),
      .pmem_rd_o(prd), .pmem_addr_o(pa), .pmem_data_i(pmd),
      .instr_valid_o(iv), .instr_kind_o(ik), .instr_byte_o(ib),
      .instr_last_o(il), .instr_len_i(len), .sys_reset_req_o(req));
   sdp_host #(.BIT(BIT)) host_inst (
      .clk_i(clk_i), .line_i(line_w), .drv_o(drv));
   // ==========
   // memory models and expectations
   function automatic logic [7:0] dm(logic [15:0] a);
      return a[15:8] ^ a[7:0] ^ 8'h5a;
   endfunction
   function automatic logic [7:0] pm(logic [3:0] a);
      return {a, ~a};
   endfunction
   function automatic logic [15:0] crc();
      logic [15:0] c;
      c = `SDP_CRC_INIT;
      for (int i = 0; i < 16; i++) begin
         c = c ^ {pm(i[3:0]), 8'h00};
         for (int k = 0; k < 8; k++) begin
            c = {c[14:0], 1'b0} ^ (c[15] ? `SDP_CRC_POLY : 16'h0000);
         end
      end
      return c;
   endfunction
   always @(posedge clk_i) begin
      if (iv === 1'b1) q.push_back({ik, il, ib});
      if (prd === 1'b1) prd_n++;
      // memories answer in the same cycle as the address
      #1;
      dmd = dm(da);
      pmd = pm(pa);
   end
   // ==========
   // tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk_i);
      #1 rst_i = 1;
      repeat (8) @(posedge clk_i);
      #1 rst_i = 0;
      repeat (4) @(posedge clk_i);
      #1 check({12'h0, oe, iv, req, lo}, 16'h0001);
      host_inst.send(`SDP_SYNC_CHAR);
   endtask
   task automatic rd_mem(input logic [15:0] a, sz, input int cnt);
      logic [7:0] v, e;
      host_inst.send(`SDP_CMD_RDMEM);
      host_inst.send(a[15:8]);
      host_inst.send(a[7:0]);
      host_inst.send(sz[15:8]);
      host_inst.send(sz[7:0]);
      for (int i = 0; i < cnt; i++) begin
         host_inst.recv(v);
         e = halt ? dm(a + 16'(i)) : `SDP_NOT_HALTED_BYTE;
         check({8'h0, v}, {8'h0, e});
      end
      if (sz != 16'h0) begin
         repeat (BIT) @(posedge clk_i);
         #1 check({15'h0, oe}, 16'h0000);
      end
   endtask
   task automatic get_crc();
      logic [7:0] h, l;
      logic [15:0] e;
      prd_n = 0;
      host_inst.send(`SDP_CMD_CRC);
      host_inst.recv(h);
      host_inst.recv(l);
      e = halt ? crc() : `SDP_NOT_HALTED_CRC;
      check({h, l}, e);
      check(16'(prd_n), halt ? 16'h0010 : 16'h0000);
   endtask
   task automatic instr(input logic [7:0] c, input int k, input logic ok);
      logic [7:0] v[5];
      logic [3:0] t;
      int e;
      q.delete();
      host_inst.send(c);
      for (int i = 0; i < k; i++) begin
         v[i] = 8'($urandom);
         host_inst.send(v[i]);
      end
      repeat (4 * BIT) @(posedge clk_i);
      e = ok ? (c == `SDP_CMD_EXEC ? k : 1) : 0;
      check(16'(q.size()), 16'(e));
      foreach (q[i]) begin
         t = {3'(c - 8'h10), i == e - 1};
         check({12'h0, q[i][11:8]}, {12'h0, t});
         if (c != `SDP_CMD_STEP)
            check({8'h0, q[i][7:0]}, {8'h0, v[i]});
      end
   endtask
   // ==========
   // main sequence and watchdog
   initial begin
      void'($urandom(70));
      do_reset();
      rd_mem(16'hffff, 16'h0002, 2);
      repeat (3) begin
         n = $urandom_range(4, 1);
         rd_mem(16'($urandom), 16'(n), n);
      end
      get_crc();
      instr(`SDP_CMD_STEP, 0, 1);
      instr(`SDP_CMD_STUFF, 1, 1);
      for (int k = 1; k <= 5; k++) begin
         #1 len = 3'(k);
         instr(`SDP_CMD_EXEC, k, 1);
      end
      #1 prot = 1;
      instr(`SDP_CMD_STEP, 0, 0);
      instr(`SDP_CMD_EXEC, 5, 0);
      #1 prot = 0;
      halt = 0;
      instr(`SDP_CMD_STUFF, 1, 0);
      rd_mem(16'($urandom), 16'h0002, 2);
      get_crc();
      #1 halt = 1;
      rd_mem(16'($urandom), 16'h0000, 4);
      do_reset();
      #1 stop = 1;
      host_inst.level(1'b0);
      repeat (3) @(posedge clk_i);
      #1 check({15'h0, req}, 16'h0001);
      host_inst.level(1'b1);
      repeat (2) @(posedge clk_i);
      #1 check({15'h0, req}, 16'h0000);
      stop = 0;
      complete_run();
   end
   initial begin
      #600000;
      bad_count++;
      complete_run();
   end
endmodule
bind sdp_serial_debug_port sdp_serial_debug_port_asserts chk_inst (
   .clk_i(clk_i), .rst_i(rst_i), .debug_serial_line_i(debug_serial_line_i),
   .debug_serial_line_o(debug_serial_line_o),
   .debug_serial_line_oe_o(debug_serial_line_oe_o),
   .cpu_halted_i(cpu_halted_i), .read_protect_i(read_protect_i),
   .stop_mode_i(stop_mode_i), .dmem_rd_o(dmem_rd_o),
   .instr_valid_o(instr_valid_o), .instr_kind_o(instr_kind_o),
   .instr_last_o(instr_last_o), .sys_reset_req_o(sys_reset_req_o));
`default_nettype wire
